// [exec_timing_model.sv]
// Purpose: execution clock and word-transfer model for branch, call, trap and bit-clear
// Assumes: one request per retired instruction, flags valid with the request
// Notes: busy stands for the modelled clock count, then a done pulse
`timescale 1ns/1ps
module exec_timing_model
  import exec_timing_pkg::*;
#(
  parameter int WAIT_W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Part configuration
  input wire logic fastFamily,
  input wire logic bus16,
  input wire logic integratedBus,
  input wire logic [WAIT_W-1:0] waitStates,
  // Retire request
  input wire logic retireValid,
  input wire opcode_t opcode,
  input wire logic oddAddr,
  input wire logic boundsTrip,
  // Flags at retire
  input wire logic signFlag,
  input wire logic zeroFlag,
  input wire logic carryFlag,
  input wire logic overflowFlag,
  input wire logic parityFlag,
  // Result
  output logic busy,
  output logic doneValid,
  output logic unsupported,
  output logic [CLK_W-1:0] clockCount,
  output logic [CLK_W-1:0] clockCountMax,
  output logic [XFER_W-1:0] wordXfers
);

  typedef struct packed {
    state_t st;
    logic busy;
    logic done;
    logic unsup;
    logic [CLK_W-1:0] clocks;
    logic [CLK_W-1:0] clocksMax;
    logic [XFER_W-1:0] xfers;
  } core_state_t;

  core_state_t s_q;
  core_state_t s_d;

  row_t row;
  logic rowUnsup;
  logic rowSpread;
  logic taken;
  logic oddEff;
  logic [ROW_W-1:0] baseClk;
  logic [CLK_W-1:0] waitAdd;
  logic [CLK_W-1:0] total;
  logic [CLK_W-1:0] spread;
  logic take;
  logic lastCycle;

  ////////////////////////////////////////////////////////////////////////////
  // Branch conditions

  always_comb begin
    taken = 1'b0;
    case (opcode)
      OP_BRANCH_IF_EQUAL: taken = zeroFlag;
      OP_BRANCH_ZERO: taken = zeroFlag;
      OP_BRANCH_NOT_EQUAL: taken = !zeroFlag;
      OP_BRANCH_NONZERO: taken = !zeroFlag;
      OP_BRANCH_SIGNED_LT: taken = signFlag ^ overflowFlag; // [R2]
      OP_BRANCH_SIGNED_GE: taken = !(signFlag ^ overflowFlag); // [R2]
      OP_BRANCH_SIGNED_LE: taken = (signFlag ^ overflowFlag) | zeroFlag; // [R3]
      OP_BRANCH_SIGNED_GT: taken = !((signFlag ^ overflowFlag) | zeroFlag); // [R3]
      OP_BRANCH_NOT_HIGHER: taken = carryFlag | zeroFlag; // [R4]
      OP_BRANCH_UNSIGNED_HIGHER: taken = !(carryFlag | zeroFlag); // [R4]
      OP_BRANCH_CARRY_SET: taken = carryFlag; // [R5]
      OP_BRANCH_CARRY_CLEAR: taken = !carryFlag; // [R5]
      OP_BRANCH_NOT_LOWER: taken = !carryFlag;
      OP_BRANCH_NEGATIVE: taken = signFlag; // [R6]
      OP_BRANCH_POSITIVE: taken = !signFlag; // [R6]
      OP_BRANCH_PARITY_EVEN: taken = parityFlag; // [R7]
      OP_BRANCH_PARITY_ODD: taken = !parityFlag; // [R7]
      OP_BRANCH_OVERFLOW: taken = overflowFlag; // [R8]
      OP_BRANCH_NO_OVERFLOW: taken = !overflowFlag; // [R8]
      default: taken = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table lookup

  always_comb begin
    row = ROW_LOCK;
    rowUnsup = 1'b0;
    rowSpread = 1'b0;
    case (opcode)
      OP_BRANCH_IF_EQUAL, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_GT,
      OP_BRANCH_UNSIGNED_HIGHER, OP_BRANCH_CARRY_SET, OP_BRANCH_SIGNED_LE,
      OP_BRANCH_SIGNED_LT, OP_BRANCH_NEGATIVE, OP_BRANCH_CARRY_CLEAR,
      OP_BRANCH_NOT_EQUAL, OP_BRANCH_NOT_HIGHER, OP_BRANCH_NOT_LOWER,
      OP_BRANCH_NO_OVERFLOW, OP_BRANCH_NONZERO, OP_BRANCH_POSITIVE,
      OP_BRANCH_PARITY_EVEN, OP_BRANCH_PARITY_ODD, OP_BRANCH_OVERFLOW,
      OP_BRANCH_ZERO: begin
        row = taken ? ROW_BRANCH_TAKEN : ROW_BRANCH_NOT; // [R1]
      end
      OP_JUMP_NEAR: row = ROW_JUMP_NEAR; // [R9]
      OP_JUMP_SHORT: row = ROW_JUMP_SHORT; // [R9]
      OP_JUMP_REGPTR16: row = ROW_JUMP_REG; // [R9]
      OP_JUMP_FAR: row = ROW_JUMP_FAR; // [R9]
      OP_JUMP_MEMPTR16: row = ROW_JUMP_MEM16; // [R10]
      OP_JUMP_MEMPTR32: row = ROW_JUMP_MEM32; // [R11]
      OP_SOFTWARE_TRAP3, OP_SOFTWARE_TRAP_IMM: row = ROW_TRAP; // [R12]
      OP_EMULATION_TRAP: begin
        row = ROW_TRAP;
        rowUnsup = fastFamily;
      end
      OP_TRAP_ON_OVERFLOW: begin
        row = overflowFlag ? ROW_TRAPV_SET : ROW_TRAPV_CLR; // [R14]
      end
      OP_EXTENDED_ADDRESS_TRAP: begin
        row = ROW_XTRAP;
        rowUnsup = !fastFamily; // [R13]
      end
      OP_BUS_LOCK_PREFIX: row = ROW_LOCK; // [R15]
      OP_CALL_NEAR: row = ROW_CALL_NEAR; // [R16]
      OP_CALL_REGPTR16: row = ROW_CALL_REG;
      OP_CALL_MEMPTR16: row = ROW_CALL_MEM16;
      OP_CALL_FAR: row = ROW_CALL_FAR; // [R17]
      OP_CALL_MEMPTR32: row = ROW_CALL_MEM32; // [R18]
      OP_NATIVE_MODE_CALL: begin
        row = ROW_NATIVE;
        rowUnsup = fastFamily;
      end
      OP_BOUNDS_CHECK: begin
        row = boundsTrip ? ROW_BOUNDS_TRIP : ROW_BOUNDS_PASS; // [R19]
        rowSpread = boundsTrip;
      end
      OP_BIT_CLEAR_REG8_CNT, OP_BIT_CLEAR_REG16_CNT: row = ROW_CLR_REG_CNT; // [R20]
      OP_BIT_CLEAR_REG8_IMM, OP_BIT_CLEAR_REG16_IMM: row = ROW_CLR_REG_IMM; // [R20]
      OP_BIT_CLEAR_MEM8_CNT: row = ROW_CLR_MEM8_CNT;
      OP_BIT_CLEAR_MEM8_IMM: row = ROW_CLR_MEM8_IMM;
      OP_BIT_CLEAR_MEM16_CNT: row = ROW_CLR_MEM16_CNT; // [R22]
      OP_BIT_CLEAR_MEM16_IMM: row = ROW_CLR_MEM16_IMM;
      OP_CLEAR_CARRY_FLAG, OP_CLEAR_DIR_FLAG: row = ROW_CLR_FLAG; // [R21]
      default: begin
        row = ROW_LOCK;
        rowUnsup = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Column select and wait-state extension

  // An 8-bit bus splits every word, so it costs like an odd access
  assign oddEff = oddAddr | !bus16;

  always_comb begin
    if (fastFamily) begin
      baseClk = oddEff ? row.fastOdd : row.fastEven; // [R23]
    end else if (integratedBus) begin
      baseClk = oddEff ? row.intOdd : row.intEven;
    end else begin
      baseClk = oddEff ? row.stdOdd : row.stdEven; // [R23]
    end
  end

  always_comb begin
    waitAdd = CLK_W'(row.xfers) * CLK_W'(waitStates); // [R24]
    if (oddEff) begin
      waitAdd = waitAdd * CLK_W'(ODD_WAIT_FACTOR); // [R24]
    end
    total = CLK_W'(baseClk) + waitAdd;
    spread = '0;
    if (rowSpread) begin
      spread = fastFamily ? CLK_W'(BOUNDS_SPREAD_FAST) : CLK_W'(BOUNDS_SPREAD_STD);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  assign take = retireValid && (s_q.st == ST_IDLE);

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        if (take) begin
          s_d.unsup = rowUnsup; // [R13]
          s_d.clocks = rowUnsup ? '0 : total; // [R25]
          s_d.clocksMax = rowUnsup ? '0 : total + spread;
          s_d.xfers = rowUnsup ? '0 : row.xfers; // [R25]
          if (rowUnsup) begin
            s_d.done = 1'b1;
          end else begin
            s_d.st = ST_EXEC;
            s_d.busy = 1'b1;
          end
        end
      end
      ST_EXEC: begin
        if (lastCycle) begin
          s_d.st = ST_IDLE;
          s_d.busy = 1'b0;
          s_d.done = 1'b1; // [R25]
        end
      end
      default: begin
        s_d.st = ST_IDLE;
        s_d.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '{st: ST_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  timing_countdown #(
    .W(CLK_W)
  ) u_countdown (
    .clk(clk),
    .reset(reset),
    .load(take && !rowUnsup),
    .loadValue(total),
    .lastCycle(lastCycle)
  );

  assign busy = s_q.busy;
  assign doneValid = s_q.done;
  assign unsupported = s_q.unsup;
  assign clockCount = s_q.clocks;
  assign clockCountMax = s_q.clocksMax;
  assign wordXfers = s_q.xfers;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic stdPart;
  assign stdPart = !fastFamily && !integratedBus;

  property p_taken_std;
    @(posedge clk) disable iff (reset)
    take && (opcode == OP_BRANCH_IF_EQUAL) && zeroFlag && stdPart
    |=> (clockCount == CLK_W'(ROW_BRANCH_TAKEN.stdOdd)) && (wordXfers == '0);
  endproperty
  a_taken_std: assert property (p_taken_std) else $error("taken branch count wrong"); // [R1]

  property p_lt_fast_not;
    @(posedge clk) disable iff (reset)
    take && (opcode == OP_BRANCH_SIGNED_LT) && !(signFlag ^ overflowFlag) && fastFamily
    |=> clockCount == CLK_W'(ROW_BRANCH_NOT.fastOdd);
  endproperty
  a_lt_fast_not: assert property (p_lt_fast_not) else $error("signed lt not-taken wrong"); // [R2]

  property p_le_taken;
    @(posedge clk) disable iff (reset)
    take && (opcode == OP_BRANCH_SIGNED_LE) && zeroFlag && fastFamily
    |=> clockCount == CLK_W'(ROW_BRANCH_TAKEN.fastOdd);
  endproperty
  a_le_taken: assert property (p_le_taken) else $error("signed le taken wrong"); // [R3]

  property p_higher_blocked;
    @(posedge clk) disable iff (reset)
    take && (opcode == OP_BRANCH_UNSIGNED_HIGHER) && carryFlag && stdPart
    |=> clockCount == CLK_W'(ROW_BRANCH_NOT.stdOdd);
  endproperty
  a_higher_blocked: assert property (p_higher_blocked) else $error("higher branch wrong"); // [R4]

  property p_jump_near;
    @(posedge clk) disable iff (reset)
    take && (opcode == OP_JUMP_NEAR) && stdPart
    |=> clockCount == CLK_W'(ROW_JUMP_NEAR.stdOdd);
  endproperty
  a_jump_near: assert property (p_jump_near) else $error("near jump count wrong"); // [R9]

  property p_trapv_clear;
    @(posedge clk) disable iff (reset)
    take && (opcode == OP_TRAP_ON_OVERFLOW) && !overflowFlag && (waitStates == '0)
    |=> clockCount == CLK_W'(ROW_TRAPV_CLR.stdOdd);
  endproperty
  a_trapv_clear: assert property (p_trapv_clear) else $error("overflow trap clear wrong"); // [R14]

  property p_xtrap_std;
    @(posedge clk) disable iff (reset)
    take && (opcode == OP_EXTENDED_ADDRESS_TRAP) && !fastFamily
    |=> doneValid && unsupported && !busy;
  endproperty
  a_xtrap_std: assert property (p_xtrap_std) else $error("extended trap not refused"); // [R13]

  property p_wait_even;
    @(posedge clk) disable iff (reset)
    take && (opcode == OP_JUMP_MEMPTR16) && stdPart && bus16 && !oddAddr
    |=> clockCount == CLK_W'(ROW_JUMP_MEM16.stdEven) + CLK_W'($past(waitStates));
  endproperty
  a_wait_even: assert property (p_wait_even) else $error("even wait extension wrong"); // [R24]

  property p_lock_length;
    @(posedge clk) disable iff (reset)
    take && (opcode == OP_BUS_LOCK_PREFIX)
    |=> busy [*2] ##1 (!busy && doneValid && (clockCount == CLK_W'(ROW_LOCK.stdOdd)));
  endproperty
  a_lock_length: assert property (p_lock_length) else $error("bus lock duration wrong"); // [R15]

  property p_done_pulse;
    @(posedge clk) disable iff (reset)
    $fell(busy) && !(take && rowUnsup) |-> doneValid ##1 !doneValid;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done pulse malformed"); // [R25]

  property p_carry_fast;
    @(posedge clk) disable iff (reset)
    take && (opcode == OP_BRANCH_CARRY_SET) && carryFlag && fastFamily
    |=> clockCount == CLK_W'(ROW_BRANCH_TAKEN.fastOdd);
  endproperty
  a_carry_fast: assert property (p_carry_fast) else $error("carry branch wrong"); // [R5]

  property p_unsup_zero;
    @(posedge clk) disable iff (reset)
    take && rowUnsup
    |=> unsupported && (clockCount == '0) && (wordXfers == '0);
  endproperty
  a_unsup_zero: assert property (p_unsup_zero) else $error("refused counts not zero"); // [R13]

  property p_trap_xfers;
    @(posedge clk) disable iff (reset)
    take && (opcode == OP_SOFTWARE_TRAP3)
    |=> wordXfers == ROW_TRAP.xfers;
  endproperty
  a_trap_xfers: assert property (p_trap_xfers) else $error("trap transfers wrong"); // [R12]

  property p_flag_clear;
    @(posedge clk) disable iff (reset)
    take && (opcode == OP_CLEAR_CARRY_FLAG)
    |=> (clockCount == CLK_W'(ROW_CLR_FLAG.fastOdd)) && (wordXfers == '0);
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag clear wrong"); // [R21]

endmodule

// [exec_timing_pkg.sv]
// Purpose: constants and types for the execution clock timing model
// Assumes: zero-wait table figures; wait states added by the model
// Notes: clock rows hold standard, integrated-bus and fast columns
// Summary of operation
// R1: Short conditional branches: no transfers; 14/4 standard, 6/3 fast clocks.
// R2: Signed less-than taken on sign xor overflow; greater-equal on its inverse.
// R3: Signed less-equal taken on (sign xor overflow) or zero; greater-than inverse.
// R4: Not-higher taken on carry or zero; higher taken when both clear.
// R5: Carry-set taken on carry 1, carry-clear on carry 0.
// R6: Negative taken on sign 1, positive on sign 0; not taken 4/3.
// R7: Parity-even taken on parity 1, parity-odd on parity 0.
// R8: Overflow branch taken on overflow 1, no-overflow on overflow 0.
// R9: Jumps near 13, short 12, register 11, far 15; fast always 7.
// R10: Jump via 16-bit memory pointer: one transfer, 24/20, fast 13/11.
// R11: Jump via 32-bit memory pointer: two transfers, 35/27, fast 17/13.
// R12: Software trap, any vector: five transfers, 50/38, fast 24/18.
// R13: Extended-address trap only on fast parts: two transfers, 12 clocks.
// R14: Trap on overflow: 3 clocks if clear; else 52/40, fast 26/20.
// R15: Bus lock prefix: no transfers, 2 clocks everywhere.
// R16: Near call: one transfer, 20/16, fast 9/7.
// R17: Far call: two transfers, 29/21, fast 13/9.
// R18: Call via 32-bit pointer: four transfers, 47/31, fast 23/15.
// R19: Bounds check trips: seven transfers, 73-76 odd; else two transfers, 26.
// R20: Register bit clear: count-register 5, immediate 6, fast 4.
// R21: Clearing carry or direction flag: 2 clocks, no transfers.
// R22: Memory word bit clear by count register: two transfers, 22/14, fast 13/9.
// R23: Figures assume zero waits; bus cycle 4 clocks standard, 2 fast.
// R24: Wait states add transfers times waits; doubled for odd addresses.
// R25: Each retired instruction reports clock count and transfer count.
package exec_timing_pkg;

  localparam int CLK_W = 10;
  localparam int ROW_W = 7;
  localparam int XFER_W = 3;
  localparam int COUNT_LAST = 1;
  localparam int BUS_CYCLE_STD = 4;
  localparam int BUS_CYCLE_FAST = 2;
  localparam int ODD_WAIT_FACTOR = 2;

  typedef enum logic [5:0] {
    OP_BRANCH_IF_EQUAL, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_GT,
    OP_BRANCH_UNSIGNED_HIGHER, OP_BRANCH_CARRY_SET, OP_BRANCH_SIGNED_LE,
    OP_BRANCH_SIGNED_LT, OP_BRANCH_NEGATIVE, OP_BRANCH_CARRY_CLEAR,
    OP_BRANCH_NOT_EQUAL, OP_BRANCH_NOT_HIGHER, OP_BRANCH_NOT_LOWER,
    OP_BRANCH_NO_OVERFLOW, OP_BRANCH_NONZERO, OP_BRANCH_POSITIVE,
    OP_BRANCH_PARITY_EVEN, OP_BRANCH_PARITY_ODD, OP_BRANCH_OVERFLOW,
    OP_BRANCH_ZERO,
    OP_JUMP_NEAR, OP_JUMP_SHORT, OP_JUMP_REGPTR16, OP_JUMP_MEMPTR16,
    OP_JUMP_FAR, OP_JUMP_MEMPTR32,
    OP_SOFTWARE_TRAP3, OP_SOFTWARE_TRAP_IMM, OP_EMULATION_TRAP,
    OP_TRAP_ON_OVERFLOW, OP_EXTENDED_ADDRESS_TRAP, OP_BUS_LOCK_PREFIX,
    OP_CALL_NEAR, OP_CALL_REGPTR16, OP_CALL_MEMPTR16, OP_CALL_FAR,
    OP_CALL_MEMPTR32, OP_NATIVE_MODE_CALL, OP_BOUNDS_CHECK,
    OP_BIT_CLEAR_REG8_CNT, OP_BIT_CLEAR_MEM8_CNT, OP_BIT_CLEAR_REG16_CNT,
    OP_BIT_CLEAR_MEM16_CNT, OP_BIT_CLEAR_REG8_IMM, OP_BIT_CLEAR_MEM8_IMM,
    OP_BIT_CLEAR_REG16_IMM, OP_BIT_CLEAR_MEM16_IMM, OP_CLEAR_CARRY_FLAG,
    OP_CLEAR_DIR_FLAG
  } opcode_t;

  typedef struct packed {
    logic [ROW_W-1:0] stdOdd;
    logic [ROW_W-1:0] stdEven;
    logic [ROW_W-1:0] intOdd;
    logic [ROW_W-1:0] intEven;
    logic [ROW_W-1:0] fastOdd;
    logic [ROW_W-1:0] fastEven;
    logic [XFER_W-1:0] xfers;
  } row_t;

  // Columns: std odd/even, integrated odd/even, fast odd/even, transfers
  localparam row_t ROW_BRANCH_TAKEN = '{7'h0e, 7'h0e, 7'h0e, 7'h0e, 7'h06, 7'h06, 3'h0};
  localparam row_t ROW_BRANCH_NOT = '{7'h04, 7'h04, 7'h04, 7'h04, 7'h03, 7'h03, 3'h0};
  localparam row_t ROW_JUMP_NEAR = '{7'h0d, 7'h0d, 7'h0d, 7'h0d, 7'h07, 7'h07, 3'h0};
  localparam row_t ROW_JUMP_SHORT = '{7'h0c, 7'h0c, 7'h0c, 7'h0c, 7'h07, 7'h07, 3'h0};
  localparam row_t ROW_JUMP_REG = '{7'h0b, 7'h0b, 7'h0b, 7'h0b, 7'h07, 7'h07, 3'h0};
  localparam row_t ROW_JUMP_MEM16 = '{7'h18, 7'h14, 7'h17, 7'h13, 7'h0d, 7'h0b, 3'h1};
  localparam row_t ROW_JUMP_FAR = '{7'h0f, 7'h0f, 7'h0f, 7'h0f, 7'h07, 7'h07, 3'h0};
  localparam row_t ROW_JUMP_MEM32 = '{7'h23, 7'h1b, 7'h22, 7'h1a, 7'h11, 7'h0d, 3'h2};
  localparam row_t ROW_TRAP = '{7'h32, 7'h26, 7'h32, 7'h26, 7'h18, 7'h12, 3'h5};
  localparam row_t ROW_TRAPV_SET = '{7'h34, 7'h28, 7'h34, 7'h28, 7'h1a, 7'h14, 3'h5};
  localparam row_t ROW_TRAPV_CLR = '{7'h03, 7'h03, 7'h03, 7'h03, 7'h03, 7'h03, 3'h5};
  localparam row_t ROW_XTRAP = '{7'h00, 7'h00, 7'h00, 7'h00, 7'h0c, 7'h0c, 3'h2};
  localparam row_t ROW_LOCK = '{7'h02, 7'h02, 7'h02, 7'h02, 7'h02, 7'h02, 3'h0};
  localparam row_t ROW_CALL_NEAR = '{7'h14, 7'h10, 7'h14, 7'h10, 7'h09, 7'h07, 3'h1};
  localparam row_t ROW_CALL_REG = '{7'h12, 7'h0e, 7'h12, 7'h0e, 7'h09, 7'h07, 3'h1};
  localparam row_t ROW_CALL_MEM16 = '{7'h1f, 7'h17, 7'h1f, 7'h17, 7'h0f, 7'h0b, 3'h2};
  localparam row_t ROW_CALL_FAR = '{7'h1d, 7'h15, 7'h1d, 7'h15, 7'h0d, 7'h09, 3'h2};
  localparam row_t ROW_CALL_MEM32 = '{7'h2f, 7'h1f, 7'h2f, 7'h1f, 7'h17, 7'h0f, 3'h4};
  localparam row_t ROW_NATIVE = '{7'h3a, 7'h26, 7'h3a, 7'h26, 7'h00, 7'h00, 3'h5};
  localparam row_t ROW_BOUNDS_TRIP = '{7'h49, 7'h35, 7'h48, 7'h34, 7'h1e, 7'h18, 3'h7};
  localparam row_t ROW_BOUNDS_PASS = '{7'h1a, 7'h12, 7'h19, 7'h11, 7'h0e, 7'h0c, 3'h2};
  localparam row_t ROW_CLR_REG_CNT = '{7'h05, 7'h05, 7'h05, 7'h05, 7'h04, 7'h04, 3'h0};
  localparam row_t ROW_CLR_MEM8_CNT = '{7'h0e, 7'h0e, 7'h0b, 7'h0b, 7'h09, 7'h09, 3'h0};
  localparam row_t ROW_CLR_MEM16_CNT = '{7'h16, 7'h0e, 7'h13, 7'h0b, 7'h0d, 7'h09, 3'h2};
  localparam row_t ROW_CLR_REG_IMM = '{7'h06, 7'h06, 7'h06, 7'h06, 7'h04, 7'h04, 3'h0};
  localparam row_t ROW_CLR_MEM8_IMM = '{7'h0f, 7'h0f, 7'h0c, 7'h0c, 7'h09, 7'h09, 3'h0};
  localparam row_t ROW_CLR_MEM16_IMM = '{7'h17, 7'h0f, 7'h14, 7'h0c, 7'h0d, 7'h09, 3'h2};
  localparam row_t ROW_CLR_FLAG = '{7'h02, 7'h02, 7'h02, 7'h02, 7'h02, 7'h02, 3'h0};

  // Upper end of the bounds-check trip range above the table's lower figure
  localparam int BOUNDS_SPREAD_STD = 3;
  localparam int BOUNDS_SPREAD_FAST = 2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_EXEC = 2'h2
  } state_t;

endpackage

// [timing_countdown.sv]
// Purpose: loadable down-counter marking the last cycle of an execution
// Assumes: load and count share the single core clock
// Notes: holds at zero when not loaded
`timescale 1ns/1ps
module timing_countdown
  import exec_timing_pkg::*;
#(
  parameter int W = CLK_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic load,
  input wire logic [W-1:0] loadValue,
  // Status
  output logic lastCycle
);

  typedef struct packed {
    logic [W-1:0] count;
  } cnt_state_t;

  cnt_state_t s_q;
  cnt_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (load) begin
      s_d.count = loadValue;
    end else if (s_q.count != '0) begin
      s_d.count = s_q.count - W'(COUNT_LAST);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign lastCycle = (s_q.count == W'(COUNT_LAST));

endmodule

// [tb_top.sv]
// Purpose: self-checking bench for the execution timing model
// Assumes: default wait-state width; inputs driven at the rising edge
// Notes: outputs are sampled 1 ns after the edge that updates them
`timescale 1ns/1ps
module tb_top
  import exec_timing_pkg::*;
;
  localparam int WAIT_W = 4;
  logic clk, reset, fastFamily, bus16, integratedBus, retireValid, oddAddr, boundsTrip;
  logic signFlag, zeroFlag, carryFlag, overflowFlag, parityFlag;
  logic [WAIT_W-1:0] waitStates;
  opcode_t opcode;
  logic busy, doneValid, unsupported;
  logic [CLK_W-1:0] clockCount, clockCountMax;
  logic [XFER_W-1:0] wordXfers;
  int mismatches, cmpCount;

  exec_timing_model #(.WAIT_W(WAIT_W)) u_dut (
    .clk(clk), .reset(reset), .fastFamily(fastFamily), .bus16(bus16),
    .integratedBus(integratedBus), .waitStates(waitStates), .retireValid(retireValid),
    .opcode(opcode), .oddAddr(oddAddr), .boundsTrip(boundsTrip), .signFlag(signFlag),
    .zeroFlag(zeroFlag), .carryFlag(carryFlag), .overflowFlag(overflowFlag),
    .parityFlag(parityFlag), .busy(busy), .doneValid(doneValid), .unsupported(unsupported),
    .clockCount(clockCount), .clockCountMax(clockCountMax), .wordXfers(wordXfers)
  );

  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic giveVerdict();
    if (mismatches == 0 && cmpCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [CLK_W-1:0] exp, logic [CLK_W-1:0] got);
    cmpCount++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0d seen %0d", nm, exp, got);
    end
  endtask

  task automatic cfg(logic f, logic b, logic i, logic [WAIT_W-1:0] w);
    @(posedge clk);
    fastFamily <= f;
    bus16 <= b;
    integratedBus <= i;
    waitStates <= w;
  endtask

  // One retire request, then results and busy length
  task automatic run(opcode_t o, logic odd, logic [4:0] f, int c, int cm, int x, logic un);
    int n = 0;
    int bn = 0;
    @(posedge clk);
    retireValid <= 1'h1;
    opcode <= o;
    oddAddr <= odd;
    {signFlag, zeroFlag, carryFlag, overflowFlag, parityFlag} <= f;
    @(posedge clk);
    retireValid <= 1'h0;
    #1;
    chk("clockCount", CLK_W'(c), clockCount);
    chk("clockCountMax", CLK_W'(cm), clockCountMax);
    chk("wordXfers", CLK_W'(x), CLK_W'(wordXfers));
    chk("unsupported", CLK_W'(un), CLK_W'(unsupported));
    while (doneValid !== 1'h1 && n < 1100) begin
      if (busy === 1'h1) bn++;
      @(posedge clk);
      #1;
      n++;
    end
    chk("busyCycles", CLK_W'(c), CLK_W'(bn));
    chk("doneValid", 10'h001, CLK_W'(doneValid));
  endtask

  task automatic both(opcode_t o, logic odd, logic [4:0] f, int s, int q, int x);
    cfg(1'h0, 1'h1, 1'h0, 4'h0);
    run(o, odd, f, s, s, x, 1'h0);
    cfg(1'h1, 1'h1, 1'h0, 4'h0);
    run(o, odd, f, q, q, x, 1'h0);
  endtask

  // Flags ordered sign, zero, carry, overflow, parity
  task automatic br(opcode_t o, logic [4:0] tk, logic [4:0] nt);
    cfg(1'h0, 1'h1, 1'h0, 4'h0);
    run(o, 1'h0, tk, 14, 14, 0, 1'h0);
    run(o, 1'h0, nt, 4, 4, 0, 1'h0);
    cfg(1'h1, 1'h1, 1'h0, 4'h0);
    run(o, 1'h1, tk, 6, 6, 0, 1'h0);
    run(o, 1'h1, nt, 3, 3, 0, 1'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_branches();
    br(OP_BRANCH_IF_EQUAL, 5'h08, 5'h17);
    br(OP_BRANCH_NOT_EQUAL, 5'h17, 5'h08);
    br(OP_BRANCH_ZERO, 5'h08, 5'h17);
    br(OP_BRANCH_NONZERO, 5'h17, 5'h08);
    br(OP_BRANCH_NOT_LOWER, 5'h1b, 5'h04);
    br(OP_BRANCH_SIGNED_LT, 5'h10, 5'h12);
    br(OP_BRANCH_SIGNED_GE, 5'h12, 5'h02);
    br(OP_BRANCH_SIGNED_LE, 5'h08, 5'h12);
    br(OP_BRANCH_SIGNED_GT, 5'h12, 5'h02);
    br(OP_BRANCH_NOT_HIGHER, 5'h04, 5'h13);
    br(OP_BRANCH_UNSIGNED_HIGHER, 5'h13, 5'h08);
    br(OP_BRANCH_CARRY_SET, 5'h04, 5'h1b);
    br(OP_BRANCH_CARRY_CLEAR, 5'h1b, 5'h04);
    br(OP_BRANCH_NEGATIVE, 5'h10, 5'h0f);
    br(OP_BRANCH_POSITIVE, 5'h0f, 5'h10);
    br(OP_BRANCH_PARITY_EVEN, 5'h01, 5'h1e);
    br(OP_BRANCH_PARITY_ODD, 5'h1e, 5'h01);
    br(OP_BRANCH_OVERFLOW, 5'h02, 5'h1d);
    br(OP_BRANCH_NO_OVERFLOW, 5'h1d, 5'h02);
  endtask

  task automatic t_table();
    both(OP_JUMP_NEAR, 1'h0, 5'h00, 13, 7, 0);
    both(OP_JUMP_SHORT, 1'h1, 5'h00, 12, 7, 0);
    both(OP_JUMP_REGPTR16, 1'h0, 5'h00, 11, 7, 0);
    both(OP_JUMP_FAR, 1'h1, 5'h00, 15, 7, 0);
    both(OP_JUMP_MEMPTR16, 1'h1, 5'h00, 24, 13, 1);
    both(OP_JUMP_MEMPTR16, 1'h0, 5'h00, 20, 11, 1);
    both(OP_JUMP_MEMPTR32, 1'h1, 5'h00, 35, 17, 2);
    both(OP_JUMP_MEMPTR32, 1'h0, 5'h00, 27, 13, 2);
    both(OP_SOFTWARE_TRAP3, 1'h1, 5'h00, 50, 24, 5);
    both(OP_SOFTWARE_TRAP_IMM, 1'h0, 5'h00, 38, 18, 5);
    both(OP_TRAP_ON_OVERFLOW, 1'h1, 5'h02, 52, 26, 5);
    both(OP_TRAP_ON_OVERFLOW, 1'h0, 5'h02, 40, 20, 5);
    both(OP_TRAP_ON_OVERFLOW, 1'h1, 5'h1d, 3, 3, 5);
    both(OP_BUS_LOCK_PREFIX, 1'h1, 5'h00, 2, 2, 0);
    both(OP_CALL_NEAR, 1'h1, 5'h00, 20, 9, 1);
    both(OP_CALL_NEAR, 1'h0, 5'h00, 16, 7, 1);
    both(OP_CALL_FAR, 1'h1, 5'h00, 29, 13, 2);
    both(OP_CALL_FAR, 1'h0, 5'h00, 21, 9, 2);
    both(OP_CALL_MEMPTR32, 1'h1, 5'h00, 47, 23, 4);
    both(OP_CALL_MEMPTR32, 1'h0, 5'h00, 31, 15, 4);
    both(OP_CALL_REGPTR16, 1'h1, 5'h00, 18, 9, 1);
    both(OP_CALL_MEMPTR16, 1'h0, 5'h00, 23, 11, 2);
    both(OP_BIT_CLEAR_MEM16_IMM, 1'h1, 5'h00, 23, 13, 2);
    both(OP_BIT_CLEAR_REG8_CNT, 1'h0, 5'h00, 5, 4, 0);
    both(OP_BIT_CLEAR_REG16_CNT, 1'h1, 5'h00, 5, 4, 0);
    both(OP_BIT_CLEAR_REG8_IMM, 1'h0, 5'h00, 6, 4, 0);
    both(OP_BIT_CLEAR_REG16_IMM, 1'h1, 5'h00, 6, 4, 0);
    both(OP_CLEAR_CARRY_FLAG, 1'h1, 5'h00, 2, 2, 0);
    both(OP_CLEAR_DIR_FLAG, 1'h0, 5'h00, 2, 2, 0);
    both(OP_BIT_CLEAR_MEM16_CNT, 1'h1, 5'h00, 22, 13, 2);
    both(OP_BIT_CLEAR_MEM16_CNT, 1'h0, 5'h00, 14, 9, 2);
  endtask

  task automatic t_bounds();
    cfg(1'h0, 1'h1, 1'h0, 4'h0);
    boundsTrip <= 1'h1;
    run(OP_BOUNDS_CHECK, 1'h1, 5'h00, 73, 76, 7, 1'h0);
    cfg(1'h1, 1'h1, 1'h0, 4'h0);
    run(OP_BOUNDS_CHECK, 1'h1, 5'h00, 30, 32, 7, 1'h0);
    cfg(1'h0, 1'h1, 1'h0, 4'h0);
    boundsTrip <= 1'h0;
    run(OP_BOUNDS_CHECK, 1'h1, 5'h00, 26, 26, 2, 1'h0);
  endtask

  task automatic t_unsupported();
    cfg(1'h0, 1'h1, 1'h0, 4'h0);
    run(OP_EXTENDED_ADDRESS_TRAP, 1'h0, 5'h00, 0, 0, 0, 1'h1);
    cfg(1'h1, 1'h1, 1'h0, 4'h0);
    run(OP_EXTENDED_ADDRESS_TRAP, 1'h1, 5'h00, 12, 12, 2, 1'h0);
    run(OP_EMULATION_TRAP, 1'h0, 5'h00, 0, 0, 0, 1'h1);
    run(OP_NATIVE_MODE_CALL, 1'h1, 5'h00, 0, 0, 0, 1'h1);
    cfg(1'h0, 1'h0, 1'h0, 4'h0);
    run(OP_NATIVE_MODE_CALL, 1'h0, 5'h00, 58, 58, 5, 1'h0);
  endtask

  // Waits add transfers times waits, doubled for odd or 8-bit access
  task automatic t_waits();
    cfg(1'h0, 1'h1, 1'h0, 4'h3);
    run(OP_JUMP_MEMPTR16, 1'h0, 5'h00, 23, 23, 1, 1'h0);
    run(OP_JUMP_MEMPTR16, 1'h1, 5'h00, 30, 30, 1, 1'h0);
    cfg(1'h0, 1'h0, 1'h0, 4'h3);
    run(OP_JUMP_MEMPTR16, 1'h0, 5'h00, 30, 30, 1, 1'h0);
    cfg(1'h1, 1'h1, 1'h0, 4'h2);
    run(OP_CALL_FAR, 1'h0, 5'h00, 13, 13, 2, 1'h0);
    run(OP_CALL_FAR, 1'h1, 5'h00, 21, 21, 2, 1'h0);
    cfg(1'h0, 1'h1, 1'h1, 4'h0);
    run(OP_JUMP_MEMPTR16, 1'h0, 5'h00, 19, 19, 1, 1'h0);
  endtask

  // Request held high while busy is ignored, then taken at done
  task automatic t_held();
    int n = 0;
    cfg(1'h0, 1'h1, 1'h0, 4'h0);
    retireValid <= 1'h1;
    opcode <= OP_JUMP_NEAR;
    oddAddr <= 1'h0;
    @(posedge clk);
    opcode <= OP_BUS_LOCK_PREFIX;
    #1;
    while (doneValid !== 1'h1 && n < 100) begin
      n++;
      @(posedge clk);
      #1;
    end
    chk("heldBusy", 10'h00d, CLK_W'(n));
    chk("heldCount", 10'h00d, clockCount);
    @(posedge clk);
    retireValid <= 1'h0;
    #1;
    chk("nextCount", 10'h002, clockCount);
    // Let the lock finish before the next request
    repeat (2) @(posedge clk);
  endtask

  task automatic t_reset();
    run(OP_BUS_LOCK_PREFIX, 1'h0, 5'h00, 2, 2, 0, 1'h0);
    @(posedge clk);
    retireValid <= 1'h1;
    opcode <= OP_JUMP_MEMPTR32;
    oddAddr <= 1'h1;
    @(posedge clk);
    retireValid <= 1'h0;
    repeat (5) @(posedge clk);
    reset <= 1'h1;
    @(posedge clk);
    reset <= 1'h0;
    #1;
    chk("resetBusy", 10'h000, CLK_W'(busy));
    chk("resetCount", 10'h000, clockCount);
    chk("resetXfers", 10'h000, CLK_W'(wordXfers));
    run(OP_BUS_LOCK_PREFIX, 1'h1, 5'h00, 2, 2, 0, 1'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'h1;
    {fastFamily, bus16, integratedBus, retireValid, oddAddr, boundsTrip} = 6'h00;
    {signFlag, zeroFlag, carryFlag, overflowFlag, parityFlag} = 5'h00;
    waitStates = 4'h0;
    opcode = OP_BUS_LOCK_PREFIX;
    repeat (3) @(posedge clk);
    reset <= 1'h0;
    t_branches();
    t_table();
    t_bounds();
    t_unsupported();
    t_waits();
    t_held();
    t_reset();
    giveVerdict();
  end

  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    giveVerdict();
  end
endmodule
